/* File: rtl/wdt_params.svh */
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// i/o ports of the configuration interface
`define WDT_INDEX_PORT 16'h002e
`define WDT_DATA_PORT 16'h002f

// key values written to the index port
`define WDT_UNLOCK_KEY 8'h87
`define WDT_LOCK_KEY 8'haa

// register indices
`define WDT_IDX_DEVICE_SELECT 8'h07
`define WDT_IDX_FUNCTION_ENABLE 8'h30
`define WDT_IDX_COUNT_UNIT 8'hf5
`define WDT_IDX_TIMEOUT_COUNT 8'hf6
`define WDT_IDX_CONTROL 8'hf7

// device number of the watchdog group
`define WDT_DEVICE_NUMBER 8'h08

// field positions
`define WDT_ENABLE_BIT 0
`define WDT_MINUTE_BIT 3
`define WDT_STATUS_BIT 4
`define WDT_FORCE_BIT 5
`define WDT_KBD_BIT 6

// reset values
`define WDT_DEVICE_SELECT_RESET 8'h00
`define WDT_FUNCTION_ENABLE_RESET 8'h00
`define WDT_COUNT_UNIT_RESET 8'h00
`define WDT_TIMEOUT_COUNT_RESET 8'h00
`define WDT_CONTROL_RESET 8'h00

// answer for a read nobody claims
`define WDT_FLOAT_DATA 8'hff

// timing
`define WDT_CLK_PERIOD_NS 10
`define WDT_SECOND_NS 1000000000
`define WDT_SEC_CYCLES (`WDT_SECOND_NS / `WDT_CLK_PERIOD_NS)
`define WDT_SECONDS_PER_MINUTE 60

`endif

/* File: rtl/wdt_pkg.sv */
package wdt_pkg;

	typedef enum logic [1:0] {
		LOCKED,
		HALF_OPEN,
		OPEN
	} lock_state_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} io_req_type;

endpackage

/* File: rtl/wdt_unit_tick.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"

module wdt_unit_tick #(
	parameter int unsigned SEC_CYCLES = `WDT_SEC_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic minutes,
	output logic unit_tick
);

	localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
	localparam logic [5:0] MIN_LAST = 6'(`WDT_SECONDS_PER_MINUTE - 1);

	logic [31:0] sec_cnt;
	logic [5:0] min_cnt;
	logic sec_tick;

	assign sec_tick = (sec_cnt == SEC_LAST);

	// a restart clears the prescaler so the first unit is a whole one
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_cnt <= 32'h00000000;
		end else if (clear || sec_tick) begin
			sec_cnt <= 32'h00000000;
		end else begin
			sec_cnt <= sec_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			min_cnt <= 6'h00;
		end else if (clear) begin
			min_cnt <= 6'h00;
		end else if (sec_tick) begin
			min_cnt <= (min_cnt == MIN_LAST) ? 6'h00 : min_cnt + 6'h01;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			unit_tick <= 1'b0;
		end else begin
			unit_tick <= !clear && sec_tick &&
				(!minutes || min_cnt == MIN_LAST);
		end
	end

endmodule
`default_nettype wire

/* File: rtl/wdt_index_port.sv */
// What this block does
// [RL1] timeout programmable 1..255 seconds or minutes
// [RL2] expiry raises interrupt or reset output
// [RL3] strap picks reset or irq 11, one only
// [RL4] interrupt low, held until timer restarted
// [RL5] 2E is index port, 2F data port
// [RL6] host writes index, then accesses data port
// [RL7] two successive 87 writes unlock access
// [RL8] AA to index port relocks access
// [RL9] 08 at index 07 maps watchdog group
// [RL10] 01 at index 30 enables; off at reset
// [RL11] F5 bit 3 picks seconds or minutes
// [RL12] F6 zero stops timer; else unit count
// [RL13] any F6 write restarts from new value
// [RL14] F7 bit 6 lets keyboard restart timer
// [RL15] F7 bit 5 forces timeout, self-clears
// [RL16] F7 bit 4 reads expired status
// [RL17] count down per unit, expire at zero
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"

module wdt_index_port #(
	parameter int unsigned SEC_CYCLES = `WDT_SEC_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire wdt_pkg::io_req_type io_req,
	output logic [7:0] io_rdata,
	input wire logic kbd_activity,
	input wire logic expiry_action_strap,
	output logic wdt_irq11_n,
	output logic wdt_sys_reset_n
);

	wdt_pkg::lock_state_type lock_state;
	logic [7:0] index;
	logic [7:0] device_select;
	logic [7:0] function_enable;
	logic [7:0] count_unit_config;
	logic [7:0] timeout_count;
	logic [7:0] control;
	logic [7:0] count_now;
	logic expired;
	logic strap_seen;
	logic strap_reset;
	logic unit_tick;

	logic index_wr;
	logic data_wr;
	logic data_rd;
	logic group_sel;
	logic count_wr;
	logic control_wr;
	logic force_timeout;
	logic kbd_restart;
	logic restart;
	logic running;
	logic expire_event;
	logic [7:0] read_value;

	function automatic logic is_reg(input logic [7:0] idx,
		input logic [7:0] which);
		is_reg = (idx == which);
	endfunction

	// port decode
	assign index_wr = io_req.wr && io_req.addr == `WDT_INDEX_PORT; // [RL5]
	assign data_wr = io_req.wr && io_req.addr == `WDT_DATA_PORT &&
		lock_state == wdt_pkg::OPEN; // [RL5]
	assign data_rd = io_req.rd && io_req.addr == `WDT_DATA_PORT &&
		lock_state == wdt_pkg::OPEN;
	assign group_sel = (device_select == `WDT_DEVICE_NUMBER); // [RL9]
	assign count_wr = data_wr && group_sel &&
		is_reg(index, `WDT_IDX_TIMEOUT_COUNT);
	assign control_wr = data_wr && group_sel &&
		is_reg(index, `WDT_IDX_CONTROL);
	assign force_timeout = control_wr &&
		io_req.wdata[`WDT_FORCE_BIT]; // [RL15]
	assign kbd_restart = kbd_activity && control[`WDT_KBD_BIT]; // [RL14]
	assign restart = count_wr || kbd_restart; // [RL13]
	assign running = function_enable[`WDT_ENABLE_BIT] &&
		count_now != 8'h00 && !expired; // [RL10] [RL12]
	assign expire_event = force_timeout ||
		(running && unit_tick && !restart && count_now == 8'h01); // [RL17]

	// unlock / lock sequencer; a key must arrive in successive writes
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_state <= wdt_pkg::LOCKED;
		end else if (index_wr) begin
			case (lock_state)
				wdt_pkg::LOCKED: begin
					if (io_req.wdata == `WDT_UNLOCK_KEY) begin
						lock_state <= wdt_pkg::HALF_OPEN; // [RL7]
					end
				end
				wdt_pkg::HALF_OPEN: begin
					if (io_req.wdata == `WDT_UNLOCK_KEY) begin
						lock_state <= wdt_pkg::OPEN; // [RL7]
					end else begin
						lock_state <= wdt_pkg::LOCKED;
					end
				end
				wdt_pkg::OPEN: begin
					if (io_req.wdata == `WDT_LOCK_KEY) begin
						lock_state <= wdt_pkg::LOCKED; // [RL8]
					end
				end
				default: begin
					lock_state <= wdt_pkg::LOCKED;
				end
			endcase
		end
	end

	// index latch; host must select before touching the data port
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			index <= 8'h00;
		end else if (index_wr && lock_state == wdt_pkg::OPEN &&
			io_req.wdata != `WDT_LOCK_KEY) begin
			index <= io_req.wdata; // [RL6]
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			device_select <= `WDT_DEVICE_SELECT_RESET;
		end else if (data_wr && is_reg(index, `WDT_IDX_DEVICE_SELECT)) begin
			device_select <= io_req.wdata; // [RL9]
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			function_enable <= `WDT_FUNCTION_ENABLE_RESET; // [RL10]
		end else if (data_wr && group_sel &&
			is_reg(index, `WDT_IDX_FUNCTION_ENABLE)) begin
			function_enable <= io_req.wdata; // [RL10]
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_unit_config <= `WDT_COUNT_UNIT_RESET; // [RL11]
		end else if (data_wr && group_sel &&
			is_reg(index, `WDT_IDX_COUNT_UNIT)) begin
			count_unit_config <= io_req.wdata; // [RL11]
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_count <= `WDT_TIMEOUT_COUNT_RESET; // [RL12]
		end else if (count_wr) begin
			timeout_count <= io_req.wdata; // [RL1]
		end
	end

	// force bit is never stored, so it always reads back as zero
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			control <= `WDT_CONTROL_RESET; // [RL14]
		end else if (control_wr) begin
			control <= io_req.wdata & 8'hcf; // [RL15]
		end
	end

	// unit prescaler, restarted together with the count
	wdt_unit_tick #(
		.SEC_CYCLES(SEC_CYCLES)
	) unit_gen (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(restart),
		.minutes(count_unit_config[`WDT_MINUTE_BIT]), // [RL11]
		.unit_tick(unit_tick)
	);

	// down counter; a keyboard restart reloads the programmed value
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_now <= 8'h00;
		end else if (count_wr) begin
			count_now <= io_req.wdata; // [RL13]
		end else if (kbd_restart) begin
			count_now <= timeout_count; // [RL14]
		end else if (running && unit_tick) begin
			count_now <= count_now - 8'h01; // [RL17]
		end
	end

	// expiry flag: a forced timeout wins over a restart in the same cycle; a restart wins over a count expiry
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			expired <= 1'b0;
		end else if (expire_event) begin
			expired <= 1'b1; // [RL2]
		end else if (restart) begin
			expired <= 1'b0; // [RL4]
		end
	end

	// the strap is static, so it is caught once after reset release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_seen <= 1'b0;
			strap_reset <= 1'b0;
		end else if (!strap_seen) begin
			strap_seen <= 1'b1;
			strap_reset <= expiry_action_strap; // [RL3]
		end
	end

	// only one of the two actions ever drives
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_irq11_n <= 1'b1;
			wdt_sys_reset_n <= 1'b1;
		end else begin
			wdt_irq11_n <= !(expired && !strap_reset); // [RL3] [RL4]
			wdt_sys_reset_n <= !(expired && strap_reset); // [RL2] [RL3]
		end
	end

	always_comb begin
		read_value = `WDT_FLOAT_DATA;
		if (is_reg(index, `WDT_IDX_DEVICE_SELECT)) begin
			read_value = device_select;
		end else if (group_sel) begin
			case (index)
				`WDT_IDX_FUNCTION_ENABLE: begin
					read_value = function_enable;
				end
				`WDT_IDX_COUNT_UNIT: begin
					read_value = count_unit_config;
				end
				`WDT_IDX_TIMEOUT_COUNT: begin
					read_value = timeout_count;
				end
				`WDT_IDX_CONTROL: begin
					read_value = control;
					read_value[`WDT_STATUS_BIT] = expired; // [RL16]
				end
				default: begin
					read_value = `WDT_FLOAT_DATA;
				end
			endcase
		end
	end

	// reads while locked see a floating bus
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			io_rdata <= `WDT_FLOAT_DATA;
		end else if (data_rd) begin
			io_rdata <= read_value; // [RL16]
		end else if (io_req.rd) begin
			io_rdata <= `WDT_FLOAT_DATA; // [RL8]
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence first_key;
		index_wr && lock_state == wdt_pkg::LOCKED &&
			io_req.wdata == `WDT_UNLOCK_KEY;
	endsequence

	// the second key may come any number of cycles after the first
	sequence second_key;
		index_wr && lock_state == wdt_pkg::HALF_OPEN &&
			io_req.wdata == `WDT_UNLOCK_KEY;
	endsequence

	sequence lock_key;
		index_wr && lock_state == wdt_pkg::OPEN &&
			io_req.wdata == `WDT_LOCK_KEY;
	endsequence

	sequence final_unit;
		running && unit_tick && !restart && count_now == 8'h01 &&
			!force_timeout;
	endsequence

	AST_FIRST_KEY: assert property ( // [RL7]
		first_key |=> lock_state == wdt_pkg::HALF_OPEN)
		else $error("first unlock key not taken");

	AST_UNLOCK_TWICE: assert property ( // [RL7]
		second_key |=> lock_state == wdt_pkg::OPEN)
		else $error("two unlock keys did not open access");

	AST_RELOCK: assert property ( // [RL8]
		lock_key |=> lock_state == wdt_pkg::LOCKED)
		else $error("lock key did not relock access");

	AST_LOCKED_IGNORES: assert property ( // [RL8]
		lock_state != wdt_pkg::OPEN && io_req.wr &&
			io_req.addr == `WDT_DATA_PORT
		|=> $stable(timeout_count) && $stable(control) &&
			$stable(function_enable))
		else $error("locked data write changed a register");

	AST_COUNT_LOAD: assert property ( // [RL13]
		count_wr |=> count_now == $past(io_req.wdata) && !expired)
		else $error("count write did not restart timer");

	AST_DECREMENT: assert property ( // [RL17]
		running && unit_tick && !restart && !force_timeout &&
			count_now > 8'h01
		|=> count_now == $past(count_now) - 8'h01 && !expired)
		else $error("count did not step down by one");

	AST_EXPIRE: assert property ( // [RL2]
		final_unit |=> expired ##1 (!wdt_irq11_n || !wdt_sys_reset_n))
		else $error("expiry did not raise an action");

	AST_STOPPED_AT_ZERO: assert property ( // [RL12]
		count_now == 8'h00 && !count_wr && !kbd_restart
		|=> count_now == 8'h00)
		else $error("timer moved while stopped");

	AST_DISABLED_HOLDS: assert property ( // [RL10]
		!function_enable[`WDT_ENABLE_BIT] && !restart
		|=> $stable(count_now))
		else $error("disabled timer counted");

	AST_FORCE: assert property ( // [RL15]
		force_timeout |=> expired && !control[`WDT_FORCE_BIT])
		else $error("forced timeout missing or bit stuck");

	AST_ONE_ACTION: assert property ( // [RL3]
		!(!wdt_irq11_n && !wdt_sys_reset_n))
		else $error("both expiry actions asserted");

	AST_IRQ_HELD: assert property ( // [RL4]
		!wdt_irq11_n && !restart && !$past(restart) |=> !wdt_irq11_n)
		else $error("interrupt released without restart");

	AST_STATUS_READ: assert property ( // [RL16]
		data_rd && group_sel && is_reg(index, `WDT_IDX_CONTROL)
		|=> io_rdata[`WDT_STATUS_BIT] == $past(expired))
		else $error("status bit does not show expiry");

	AST_KBD_RESTART: assert property ( // [RL14]
		kbd_restart && !count_wr && !force_timeout
		|=> count_now == $past(timeout_count) && !expired)
		else $error("keyboard did not restart timer");

endmodule
`default_nettype wire

/* File: verification/wdt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"
module wdt_host_model (
	input wire logic core_clk,
	output var wdt_pkg::io_req_type io_req,
	input wire logic [7:0] io_rdata
);
	initial io_req = '{16'hffff, 8'hff, 1'b0, 1'b0};
	// idle bus shows inverted values so stale data is never mistaken
	task automatic put(input logic [15:0] a, input logic [7:0] d,
		input logic w);
		@(negedge core_clk);
		io_req <= '{a, d, w, !w};
		@(negedge core_clk);
		io_req <= '{~a, ~d, 1'b0, 1'b0};
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		put(`WDT_INDEX_PORT, idx, 1'b1);
		put(`WDT_DATA_PORT, d, 1'b1);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		put(`WDT_INDEX_PORT, idx, 1'b1);
		put(`WDT_DATA_PORT, 8'h00, 1'b0);
		@(negedge core_clk);
		d = io_rdata;
	endtask
	task automatic unlock();
		put(`WDT_INDEX_PORT, `WDT_UNLOCK_KEY, 1'b1);
		put(`WDT_INDEX_PORT, `WDT_UNLOCK_KEY, 1'b1);
		wr(`WDT_IDX_DEVICE_SELECT, `WDT_DEVICE_NUMBER);
	endtask
	task automatic lock();
		put(`WDT_INDEX_PORT, `WDT_LOCK_KEY, 1'b1);
	endtask
endmodule
`default_nettype wire

/* File: verification/wdt_index_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module wdt_index_port_bench;
	localparam int unsigned SEC = 10;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic kbd_activity = 1'b0;
	logic expiry_action_strap = 1'b0;
	wdt_pkg::io_req_type io_req;
	logic [7:0] io_rdata;
	logic wdt_irq11_n;
	logic wdt_sys_reset_n;
	logic [7:0] rv;
	logic [31:0] seed = 32'h4477;
	int errors = 0;
	int n_tests = 0;
	always #5 core_clk = ~core_clk;
	wdt_index_port #(.SEC_CYCLES(SEC)) i_wdt_index_port (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.io_req(io_req),
		.io_rdata(io_rdata),
		.kbd_activity(kbd_activity),
		.expiry_action_strap(expiry_action_strap),
		.wdt_irq11_n(wdt_irq11_n),
		.wdt_sys_reset_n(wdt_sys_reset_n)
	);
	wdt_host_model i_wdt_host_model (
		.core_clk(core_clk),
		.io_req(io_req),
		.io_rdata(io_rdata)
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic int exp_cycles(input logic [7:0] n, input logic m);
		return int'(n) * SEC * (m ? 60 : 1);
	endfunction
	function automatic logic sel_out();
		return expiry_action_strap ? wdt_sys_reset_n : wdt_irq11_n;
	endfunction
	task automatic test_done();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic do_reset(input logic strap);
		@(negedge core_clk);
		reset_n = 1'b0;
		expiry_action_strap = strap;
		repeat (8) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		`CHK({wdt_irq11_n, wdt_sys_reset_n}, 2'b11)
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		i_wdt_host_model.rd(idx, rv);
		`CHK(rv, e)
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_wdt_host_model.wr(idx, d);
	endtask
	// load a count, then time the selected expiry output
	task automatic expire(input logic [7:0] n, input logic m);
		int c;
		c = 2;
		wr(`WDT_IDX_TIMEOUT_COUNT, n);
		repeat (2) @(negedge core_clk);
		`CHK(sel_out(), 1'b1)
		while (sel_out() && c < exp_cycles(n, m) + 8) begin
			@(negedge core_clk);
			c++;
		end
		// one cycle to set the flag, one more for the registered pin
		`CHK(c, exp_cycles(n, m) + 2)
		`CHK(sel_out(), 1'b0)
		`CHK(strap_other(), 1'b1)
	endtask
	function automatic logic strap_other();
		return expiry_action_strap ? wdt_irq11_n : wdt_sys_reset_n;
	endfunction
	// the longest case is a 255 unit count; all tests need ~3600 cycles
	initial begin
		repeat (10000) @(posedge core_clk);
		errors++;
		test_done();
	end
	initial begin
		do_reset(1'b0);
		rdchk(`WDT_IDX_DEVICE_SELECT, `WDT_FLOAT_DATA);
		i_wdt_host_model.put(`WDT_INDEX_PORT, `WDT_UNLOCK_KEY, 1'b1);
		i_wdt_host_model.put(`WDT_INDEX_PORT, 8'h55, 1'b1);
		i_wdt_host_model.put(`WDT_INDEX_PORT, `WDT_UNLOCK_KEY, 1'b1);
		rdchk(`WDT_IDX_DEVICE_SELECT, `WDT_FLOAT_DATA);
		i_wdt_host_model.unlock();
		wr(`WDT_IDX_DEVICE_SELECT, 8'h05);
		rdchk(`WDT_IDX_FUNCTION_ENABLE, `WDT_FLOAT_DATA);
		wr(`WDT_IDX_DEVICE_SELECT, `WDT_DEVICE_NUMBER);
		rdchk(`WDT_IDX_FUNCTION_ENABLE, 8'h00);
		rdchk(`WDT_IDX_COUNT_UNIT, 8'h00);
		rdchk(`WDT_IDX_TIMEOUT_COUNT, 8'h00);
		rdchk(`WDT_IDX_CONTROL, 8'h00);
		wr(`WDT_IDX_TIMEOUT_COUNT, 8'h01);
		repeat (3 * SEC) @(negedge core_clk);
		`CHK(wdt_irq11_n, 1'b1)
		wr(`WDT_IDX_FUNCTION_ENABLE, 8'h01);
		wr(`WDT_IDX_TIMEOUT_COUNT, 8'h00);
		repeat (3 * SEC) @(negedge core_clk);
		`CHK(wdt_irq11_n, 1'b1)
		expire(8'h01, 1'b0);
		rdchk(`WDT_IDX_CONTROL, 8'h10);
		repeat (3) begin
			seed = xs(seed);
			expire(8'(seed % 4) + 8'h01, 1'b0);
		end
		expire(8'hff, 1'b0);
		wr(`WDT_IDX_COUNT_UNIT, 8'h08);
		rdchk(`WDT_IDX_COUNT_UNIT, 8'h08);
		expire(8'h01, 1'b1);
		wr(`WDT_IDX_COUNT_UNIT, 8'h00);
		i_wdt_host_model.lock();
		wr(`WDT_IDX_TIMEOUT_COUNT, 8'h03);
		repeat (3) @(negedge core_clk);
		`CHK(wdt_irq11_n, 1'b0)
		i_wdt_host_model.unlock();
		rdchk(`WDT_IDX_TIMEOUT_COUNT, 8'h01);
		wr(`WDT_IDX_CONTROL, 8'h40);
		rdchk(`WDT_IDX_CONTROL, 8'h50);
		repeat (6) begin
			kbd_activity = 1'b1;
			@(negedge core_clk);
			kbd_activity = 1'b0;
			repeat (4) @(negedge core_clk);
			`CHK(wdt_irq11_n, 1'b1)
		end
		wr(`WDT_IDX_CONTROL, 8'h00);
		// keyboard noise must not hold off expiry once disabled
		repeat (2 * SEC + 4) begin
			seed = xs(seed);
			kbd_activity = seed[0];
			@(negedge core_clk);
		end
		kbd_activity = 1'b0;
		`CHK(wdt_irq11_n, 1'b0)
		do_reset(1'b1);
		i_wdt_host_model.unlock();
		wr(`WDT_IDX_FUNCTION_ENABLE, 8'h01);
		wr(`WDT_IDX_CONTROL, 8'h20);
		repeat (2) @(negedge core_clk);
		`CHK({wdt_sys_reset_n, wdt_irq11_n}, 2'b01)
		rdchk(`WDT_IDX_CONTROL, 8'h10);
		expire(8'h02, 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
